/* File: common/adckmp_pkg.sv */
package adckmp_pkg;
    // kernel state configuration word layout
    localparam int KSC_ON_BIT = 0;
    localparam int KSC_ON_WP_BIT = 1;
    localparam int KSC_NOM_LSB = 4;
    localparam int KSC_NOM_WP_BIT = 7;
    localparam int KSC_SUM_LSB = 8;
    localparam int KSC_SUM_WP_BIT = 11;
    localparam int KSC_COM_LSB = 12;
    localparam int KSC_COM_WP_BIT = 15;
    localparam logic [15:0] KSC_RESET = 16'h0000;

    localparam logic [1:0] KMODE_RUN0 = 2'h0;
    localparam logic [1:0] KMODE_RUN1 = 2'h1;
    localparam logic [1:0] KMODE_STOP0 = 2'h2;
    localparam logic [1:0] KMODE_STOP1 = 2'h3;

    localparam logic [1:0] PWR_OFF = 2'h0;
    localparam logic [1:0] PWR_SLOW = 2'h1;
    localparam logic [1:0] PWR_FAST = 2'h2;
    localparam logic [1:0] PWR_ON = 2'h3;

    // global control reset: analog and arbiter dividers at max
    localparam logic [5:0] ANA_DIV_RESET = 6'h3F;
    localparam logic [1:0] ARB_DIV_RESET = 2'h3;
    localparam logic [1:0] PWR_RESET = 2'h0;

    localparam int CLK_MHZ = 50;
    localparam int WAKE_SLOW_NS = 10000;
    localparam int WAKE_FAST_NS = 3000;
    localparam int WAKE_SLOW_CYC = (WAKE_SLOW_NS * CLK_MHZ) / 1000;
    localparam int WAKE_FAST_CYC = (WAKE_FAST_NS * CLK_MHZ) / 1000;
    localparam int CONV_TICKS = 12;
    localparam int ARB_ROUND_TICKS = 4;

    typedef enum logic [2:0] {
        ADCKMP_OFF,
        ADCKMP_IDLE,
        ADCKMP_WAKE,
        ADCKMP_CONV
    } adckmp_conv_t;
endpackage

/* File: core/adckmp_clkdiv.sv */
`timescale 1ns/100ps
// divide-by-(div+1) enable pulse generator
module adckmp_clkdiv
    import adckmp_pkg::*;
#(
    parameter int W = 6
)
(
    // clock and reset
    input wire logic clock_in,
    input wire logic rstn_in,
    // control
    input wire logic run_in,
    input wire logic [W-1:0] div_in,
    // enable pulse
    output logic tick_out
);
    logic [W-1:0] cnt_reg;

    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            cnt_reg <= '0;
            tick_out <= 1'b0;
        end
        else if (!run_in)
        begin
            cnt_reg <= '0;
            tick_out <= 1'b0;
        end
        else if (cnt_reg >= div_in)
        begin
            cnt_reg <= '0;
            tick_out <= 1'b1;
        end
        else
        begin
            cnt_reg <= cnt_reg + W'(1);
            tick_out <= 1'b0;
        end
    end

    // a divide of two or more never gives back-to-back ticks
    property p_tick_period;
        @(posedge clock_in) disable iff (!rstn_in)
        (tick_out && run_in && div_in != '0 && $stable(div_in)) |=> !tick_out;
    endproperty
    a_tick_period : assert property (p_tick_period) else $error("tick too soon");
endmodule

/* File: core/adckmp_core.sv */
`timescale 1ns/100ps
// Function
// - no suspend or clock-off pending: normal mode field governs, clock runs.
// - suspend pending: suspend mode field governs, registers stay accessible.
// - clock-off: clock-off field governs; clock gated once kernels stopped.
// - one shared kernel state register sets behaviour of all kernels.
// - requests start only in run modes; frozen, not dropped, in stop.
// - mode codes: 00 run0, 01 run1 same, 10 stop0, 11 stop1.
// - stop0: finish running conversion, no new starts, arbiter continues.
// - stop1: as stop0, plus arbiter halts after current round.
// - disabled or clock stopped: only kernel state register accessible.
// - power select 00: converter off, in reset, no conversion.
// - power select 11: converter always active, no wake delay.
// - converter clock derived from module clock by analog divider.
// - arbiter clock derived from module clock by digital divider.
// - other digital logic runs on the undivided module clock.
// - clearing module enable switches module off at once, clock stopped.
// - field updates only with protect bit set; protect bits read zero.
module adckmp_core
    import adckmp_pkg::*;
#(
    parameter int ANA_DIV_W = 6,
    parameter int ARB_DIV_W = 2,
    parameter int WAKE_SLOW = WAKE_SLOW_CYC
)
(
    // clock and reset
    input wire logic clock_in,
    input wire logic rstn_in,
    // system state controller requests
    input wire logic suspend_req_in,
    input wire logic clockoff_req_in,
    // kernel state configuration write/read
    input wire logic ksc_wr_in,
    input wire logic [15:0] ksc_wdata_in,
    output logic [15:0] ksc_rdata_out,
    // global control settings
    input wire logic [1:0] converter_power_sel_in,
    input wire logic [ANA_DIV_W-1:0] analog_clk_divider_in,
    input wire logic [ARB_DIV_W-1:0] arbiter_clk_divider_in,
    // other register access request
    input wire logic reg_access_in,
    output logic reg_access_ok_out,
    // conversion request from request sources
    input wire logic conv_req_in,
    output logic conv_start_out,
    output logic conv_done_out,
    // status
    output logic [1:0] kernel_mode_out,
    output logic module_clk_en_out,
    output logic converter_reset_out,
    output logic converter_active_out,
    output logic converter_tick_out,
    output logic arbiter_tick_out,
    output logic arbiter_round_end_out
);
    logic module_on_bit_reg;
    logic [1:0] normal_op_kernel_mode_reg;
    logic [1:0] suspend_kernel_mode_reg;
    logic [1:0] clockoff_kernel_mode_reg;
    logic [1:0] mode_sel;
    logic is_stop;
    logic clk_stopped_reg;
    logic arb_halted;
    logic [$clog2(ARB_ROUND_TICKS)-1:0] arb_cnt_reg;
    logic [15:0] wake_cnt_reg;
    logic [$clog2(CONV_TICKS+1)-1:0] conv_cnt_reg;
    logic sync_susp_1_reg;
    logic sync_susp_2_reg;
    logic sync_coff_1_reg;
    logic sync_coff_2_reg;
    logic pending_reg;
    adckmp_conv_t state_reg;
    logic conv_tick;
    logic arb_tick;
    logic div_run;

    // requests come from another controller; synchronise before use
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            sync_susp_1_reg <= 1'b0;
            sync_susp_2_reg <= 1'b0;
            sync_coff_1_reg <= 1'b0;
            sync_coff_2_reg <= 1'b0;
        end
        else
        begin
            sync_susp_1_reg <= suspend_req_in;
            sync_susp_2_reg <= sync_susp_1_reg;
            sync_coff_1_reg <= clockoff_req_in;
            sync_coff_2_reg <= sync_coff_1_reg;
        end
    end

    // protected field writes; the register is shared by all kernels
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            module_on_bit_reg <= KSC_RESET[KSC_ON_BIT];
            normal_op_kernel_mode_reg <= KSC_RESET[KSC_NOM_LSB +: 2];
            suspend_kernel_mode_reg <= KSC_RESET[KSC_SUM_LSB +: 2];
            clockoff_kernel_mode_reg <= KSC_RESET[KSC_COM_LSB +: 2];
        end
        else if (ksc_wr_in)
        begin
            if (ksc_wdata_in[KSC_ON_WP_BIT])
                module_on_bit_reg <= ksc_wdata_in[KSC_ON_BIT];
            if (ksc_wdata_in[KSC_NOM_WP_BIT])
                normal_op_kernel_mode_reg <= ksc_wdata_in[KSC_NOM_LSB +: 2];
            if (ksc_wdata_in[KSC_SUM_WP_BIT])
                suspend_kernel_mode_reg <= ksc_wdata_in[KSC_SUM_LSB +: 2];
            if (ksc_wdata_in[KSC_COM_WP_BIT])
                clockoff_kernel_mode_reg <= ksc_wdata_in[KSC_COM_LSB +: 2];
        end
    end

    // protect and reserved bits read zero
    always_comb
    begin
        ksc_rdata_out = 16'h0000;
        ksc_rdata_out[KSC_ON_BIT] = module_on_bit_reg;
        ksc_rdata_out[KSC_NOM_LSB +: 2] = normal_op_kernel_mode_reg;
        ksc_rdata_out[KSC_SUM_LSB +: 2] = suspend_kernel_mode_reg;
        ksc_rdata_out[KSC_COM_LSB +: 2] = clockoff_kernel_mode_reg;
    end

    // clock-off wins over suspend, normal otherwise
    always_comb
    begin
        if (sync_coff_2_reg)
            mode_sel = clockoff_kernel_mode_reg;
        else if (sync_susp_2_reg)
            mode_sel = suspend_kernel_mode_reg;
        else
            mode_sel = normal_op_kernel_mode_reg;
    end

    assign kernel_mode_out = mode_sel;
    assign is_stop = mode_sel[1];

    // clock gated once the kernel has reached its stop state in clock-off
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
            clk_stopped_reg <= 1'b0;
        else
            clk_stopped_reg <= sync_coff_2_reg && is_stop && state_reg != ADCKMP_CONV
                && (mode_sel != KMODE_STOP1 || arb_halted);
    end

    assign module_clk_en_out = module_on_bit_reg && !clk_stopped_reg;
    assign reg_access_ok_out = reg_access_in && module_clk_en_out;

    // divided clocks run off the module clock as enables
    assign div_run = module_clk_en_out;

    adckmp_clkdiv #(.W(ANA_DIV_W)) u_analog_div
    (
        .clock_in(clock_in),
        .rstn_in(rstn_in),
        .run_in(div_run),
        .div_in(analog_clk_divider_in),
        .tick_out(conv_tick)
    );

    adckmp_clkdiv #(.W(ARB_DIV_W)) u_arbiter_div
    (
        .clock_in(clock_in),
        .rstn_in(rstn_in),
        .run_in(div_run),
        .div_in(arbiter_clk_divider_in),
        .tick_out(arb_tick)
    );

    assign converter_tick_out = conv_tick;
    assign arbiter_tick_out = arb_tick;

    // arbiter rounds; stop1 halts only at a round boundary
    assign arb_halted = (mode_sel == KMODE_STOP1) && arb_cnt_reg == '0;

    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
            arb_cnt_reg <= '0;
        else if (!module_clk_en_out)
            arb_cnt_reg <= arb_cnt_reg;
        else if (arb_tick && !arb_halted)
            arb_cnt_reg <= arb_cnt_reg + 1'b1;
    end

    assign arbiter_round_end_out = arb_tick && !arb_halted
        && arb_cnt_reg == $clog2(ARB_ROUND_TICKS)'(ARB_ROUND_TICKS - 1);

    // request held until a start; stop modes freeze it, never drop it
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
            pending_reg <= 1'b0;
        else if (conv_req_in)
            pending_reg <= 1'b1; // set wins over the start clear
        else if (conv_start_out)
            pending_reg <= 1'b0;
    end

    // converter power and conversion sequencer
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            state_reg <= ADCKMP_OFF;
            wake_cnt_reg <= '0;
            conv_cnt_reg <= '0;
        end
        else if (!module_on_bit_reg || converter_power_sel_in == PWR_OFF)
        begin
            state_reg <= ADCKMP_OFF;
            wake_cnt_reg <= '0;
            conv_cnt_reg <= '0;
        end
        else if (module_clk_en_out)
        begin
            case (state_reg)
                ADCKMP_OFF:
                    state_reg <= ADCKMP_IDLE;
                ADCKMP_IDLE:
                    if (pending_reg && !is_stop)
                    begin
                        conv_cnt_reg <= '0;
                        if (converter_power_sel_in == PWR_SLOW)
                        begin
                            wake_cnt_reg <= 16'(WAKE_SLOW);
                            state_reg <= ADCKMP_WAKE;
                        end
                        else if (converter_power_sel_in == PWR_FAST)
                        begin
                            wake_cnt_reg <= 16'(WAKE_FAST_CYC);
                            state_reg <= ADCKMP_WAKE;
                        end
                        else
                            state_reg <= ADCKMP_CONV;
                    end
                ADCKMP_WAKE:
                    if (wake_cnt_reg <= 16'h0001)
                        state_reg <= ADCKMP_CONV;
                    else
                        wake_cnt_reg <= wake_cnt_reg - 16'h0001;
                ADCKMP_CONV:
                    // a running conversion finishes even in stop modes; only module disable or power select 00 ends it early
                    if (conv_tick)
                    begin
                        if (conv_cnt_reg == $bits(conv_cnt_reg)'(CONV_TICKS - 1))
                            state_reg <= ADCKMP_IDLE;
                        else
                            conv_cnt_reg <= conv_cnt_reg + 1'b1;
                    end
                default:
                    state_reg <= ADCKMP_OFF;
            endcase
        end
    end

    assign conv_start_out = module_clk_en_out && state_reg == ADCKMP_IDLE
        && pending_reg && !is_stop && converter_power_sel_in != PWR_OFF;
    assign conv_done_out = module_clk_en_out && state_reg == ADCKMP_CONV && conv_tick
        && conv_cnt_reg == $bits(conv_cnt_reg)'(CONV_TICKS - 1);
    assign converter_reset_out = state_reg == ADCKMP_OFF;
    // stand-by modes idle the converter between conversions
    assign converter_active_out = converter_power_sel_in == PWR_ON
        ? state_reg != ADCKMP_OFF
        : (state_reg == ADCKMP_CONV || state_reg == ADCKMP_WAKE);

    property p_no_start_stop;
        @(posedge clock_in) disable iff (!rstn_in)
        is_stop |-> !conv_start_out;
    endproperty
    a_no_start_stop : assert property (p_no_start_stop) else $error("start in stop mode");

    property p_frozen_kept;
        @(posedge clock_in) disable iff (!rstn_in)
        (pending_reg && is_stop) |=> pending_reg;
    endproperty
    a_frozen_kept : assert property (p_frozen_kept) else $error("frozen request lost");

    property p_coff_prio;
        @(posedge clock_in) disable iff (!rstn_in)
        (sync_coff_2_reg && sync_susp_2_reg) |-> kernel_mode_out == clockoff_kernel_mode_reg;
    endproperty
    a_coff_prio : assert property (p_coff_prio) else $error("clock-off not preferred");

    property p_susp_mode;
        @(posedge clock_in) disable iff (!rstn_in)
        (!sync_coff_2_reg && sync_susp_2_reg) |-> kernel_mode_out == suspend_kernel_mode_reg;
    endproperty
    a_susp_mode : assert property (p_susp_mode) else $error("suspend field not applied");

    property p_norm_mode;
        @(posedge clock_in) disable iff (!rstn_in)
        (!sync_coff_2_reg && !sync_susp_2_reg) |-> kernel_mode_out == normal_op_kernel_mode_reg;
    endproperty
    a_norm_mode : assert property (p_norm_mode) else $error("normal field not applied");

    property p_protect;
        @(posedge clock_in) disable iff (!rstn_in)
        (ksc_wr_in && !ksc_wdata_in[KSC_NOM_WP_BIT]) |=> $stable(normal_op_kernel_mode_reg);
    endproperty
    a_protect : assert property (p_protect) else $error("unprotected field changed");

    property p_off_reset;
        @(posedge clock_in) disable iff (!rstn_in)
        (converter_power_sel_in == PWR_OFF) |=> converter_reset_out;
    endproperty
    a_off_reset : assert property (p_off_reset) else $error("converter not held off");

    property p_disable_now;
        @(posedge clock_in) disable iff (!rstn_in)
        !module_on_bit_reg |-> (!module_clk_en_out && !reg_access_ok_out);
    endproperty
    a_disable_now : assert property (p_disable_now) else $error("disabled module accessible");

    property p_stop1_halt;
        @(posedge clock_in) disable iff (!rstn_in)
        arb_halted |=> arb_cnt_reg == '0;
    endproperty
    a_stop1_halt : assert property (p_stop1_halt) else $error("arbiter ran in stop1");

    property p_on_nowake;
        @(posedge clock_in) disable iff (!rstn_in)
        (conv_start_out && converter_power_sel_in == PWR_ON) |=> state_reg == ADCKMP_CONV;
    endproperty
    a_on_nowake : assert property (p_on_nowake) else $error("wake delay in always-on");
endmodule

/* File: bench/adckmp_sysctl_model.sv */
`timescale 1ns/100ps
module adckmp_sysctl_model
(
    // clock and reset
    input wire logic clock_in,
    input wire logic rstn_in,
    // commands from the bench
    input wire logic suspend_cmd_in,
    input wire logic clockoff_cmd_in,
    // operating mode requests
    output logic suspend_req_out,
    output logic clockoff_req_out
);
    // requests are levels, launched just after an edge, held until withdrawn
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            suspend_req_out <= 1'b0;
            clockoff_req_out <= 1'b0;
        end
        else
        begin
            suspend_req_out <= suspend_cmd_in;
            clockoff_req_out <= clockoff_cmd_in;
        end
    end
endmodule

/* File: bench/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    import adckmp_pkg::*;
    localparam int WAKE_SIM = 20;
    logic clock_in = 1'b0;
    logic rstn_in = 1'b0;
    logic suspend_cmd = 1'b0;
    logic clockoff_cmd = 1'b0;
    logic suspend_req;
    logic clockoff_req;
    logic ksc_wr_in = 1'b0;
    logic [15:0] ksc_wdata_in = 16'h0000;
    logic [15:0] ksc_rdata_out;
    logic [1:0] converter_power_sel_in = PWR_OFF;
    logic [5:0] analog_clk_divider_in = 6'h00;
    logic [1:0] arbiter_clk_divider_in = 2'h0;
    logic reg_access_in = 1'b0;
    logic reg_access_ok_out;
    logic conv_req_in = 1'b0;
    logic conv_start_out;
    logic conv_done_out;
    logic [1:0] kernel_mode_out;
    logic module_clk_en_out;
    logic converter_reset_out;
    logic converter_active_out;
    logic converter_tick_out;
    logic arbiter_tick_out;
    logic arbiter_round_end_out;
    int err_count = 0;
    int check_count = 0;
    int cnt_tick, cnt_arb, cnt_end, cnt_start, cnt_done;
    integer seed = 32'h0000_6dac;
    logic [15:0] ksc_m = KSC_RESET;

    always #10 clock_in = ~clock_in;
    // other register accesses arrive at random to exercise the grant
    always @(posedge clock_in) reg_access_in <= 1'($random(seed));

    adckmp_sysctl_model i_ctl (.clock_in(clock_in), .rstn_in(rstn_in),
        .suspend_cmd_in(suspend_cmd), .clockoff_cmd_in(clockoff_cmd),
        .suspend_req_out(suspend_req), .clockoff_req_out(clockoff_req));

    adckmp_core #(.WAKE_SLOW(WAKE_SIM)) i_dut (.clock_in(clock_in), .rstn_in(rstn_in),
        .suspend_req_in(suspend_req), .clockoff_req_in(clockoff_req),
        .ksc_wr_in(ksc_wr_in), .ksc_wdata_in(ksc_wdata_in), .ksc_rdata_out(ksc_rdata_out),
        .converter_power_sel_in(converter_power_sel_in),
        .analog_clk_divider_in(analog_clk_divider_in),
        .arbiter_clk_divider_in(arbiter_clk_divider_in),
        .reg_access_in(reg_access_in), .reg_access_ok_out(reg_access_ok_out),
        .conv_req_in(conv_req_in), .conv_start_out(conv_start_out),
        .conv_done_out(conv_done_out), .kernel_mode_out(kernel_mode_out),
        .module_clk_en_out(module_clk_en_out), .converter_reset_out(converter_reset_out),
        .converter_active_out(converter_active_out), .converter_tick_out(converter_tick_out),
        .arbiter_tick_out(arbiter_tick_out), .arbiter_round_end_out(arbiter_round_end_out));

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask

    // pulse counts may straddle the window edge, so one either way is allowed
    task automatic near(input string what, input int exp, input int got);
        check_count++;
        if (got < exp - 1 || got > exp + 1)
        begin
            $display("ERROR %s expected %0d seen %0d", what, exp, got);
            err_count++;
        end
    endtask

    function automatic logic [15:0] ksc_expect(input logic [15:0] old, input logic [15:0] w);
        logic [15:0] r;
        r = old;
        if (w[KSC_ON_WP_BIT]) r[KSC_ON_BIT] = w[KSC_ON_BIT];
        if (w[KSC_NOM_WP_BIT]) r[KSC_NOM_LSB +: 2] = w[KSC_NOM_LSB +: 2];
        if (w[KSC_SUM_WP_BIT]) r[KSC_SUM_LSB +: 2] = w[KSC_SUM_LSB +: 2];
        if (w[KSC_COM_WP_BIT]) r[KSC_COM_LSB +: 2] = w[KSC_COM_LSB +: 2];
        return r;
    endfunction

    task automatic ksc_write(input logic [15:0] w);
        @(posedge clock_in);
        ksc_wr_in <= 1'b1;
        ksc_wdata_in <= w;
        @(posedge clock_in);
        ksc_wr_in <= 1'b0;
        ksc_m = ksc_expect(ksc_m, w);
        #1;
        check("ksc readback", ksc_m, ksc_rdata_out);
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask

    task automatic watch(input int n);
        cnt_tick = 0;
        cnt_arb = 0;
        cnt_end = 0;
        cnt_start = 0;
        cnt_done = 0;
        repeat (n)
        begin
            @(posedge clock_in);
            #1;
            if (converter_tick_out === 1'b1) cnt_tick++;
            if (arbiter_tick_out === 1'b1) cnt_arb++;
            if (arbiter_round_end_out === 1'b1) cnt_end++;
            if (conv_start_out === 1'b1) cnt_start++;
            if (conv_done_out === 1'b1) cnt_done++;
        end
    endtask

    task automatic pulse_req();
        @(posedge clock_in);
        conv_req_in <= 1'b1;
        @(posedge clock_in);
        conv_req_in <= 1'b0;
        #1;
    endtask

    task automatic conv_run(input int lo, input int hi);
        int n;
        n = 0;
        pulse_req();
        while (conv_done_out !== 1'b1 && n < hi + 20)
        begin
            @(posedge clock_in);
            #1;
            n++;
        end
        check("conversion latency in range", 16'h0001, 16'(n >= lo && n <= hi));
    endtask

    task automatic check_access(input logic allowed);
        check("register grant", {15'h0, reg_access_in & allowed}, {15'h0, reg_access_ok_out});
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clock_in);
        err_count++;
        give_verdict();
    end

    initial
    begin
        logic [15:0] w;
        int d;
        repeat (2) @(posedge clock_in);
        rstn_in <= 1'b1;
        #1;
        check("ksc after reset", KSC_RESET, ksc_rdata_out);
        check("clock gated in reset", 16'h0000, {15'h0, module_clk_en_out});
        check("converter held", 16'h0001, {15'h0, converter_reset_out});
        check_access(1'b0);
        ksc_write(16'h0001);
        ksc_write(16'h0003);
        check("clock running", 16'h0001, {15'h0, module_clk_en_out});
        check_access(1'b1);
        // random fields stay clear of the second stop type, enable untouched
        for (int i = 0; i < 24; i++)
        begin
            w = 16'($random(seed));
            w[KSC_ON_WP_BIT] = 1'b0;
            for (int f = 4; f <= 12; f += 4)
                if (w[f +: 2] == KMODE_STOP1) w[f +: 2] = KMODE_STOP0;
            ksc_write(w);
            check("normal mode applied", {14'h0, ksc_m[5:4]}, {14'h0, kernel_mode_out});
        end
        // suspend field mirrors the normal one, so suspend changes nothing
        ksc_write(16'h0880);
        suspend_cmd <= 1'b1;
        cycles(5);
        check("suspend ignored", {14'h0, KMODE_RUN0}, {14'h0, kernel_mode_out});
        ksc_write(16'hA980);
        cycles(5);
        check("suspend mode applied", {14'h0, KMODE_RUN1}, {14'h0, kernel_mode_out});
        check_access(1'b1);
        clockoff_cmd <= 1'b1;
        cycles(5);
        check("clock-off wins", {14'h0, KMODE_STOP0}, {14'h0, kernel_mode_out});
        d = 0;
        while (module_clk_en_out !== 1'b0 && d < 30)
        begin
            cycles(1);
            d++;
        end
        check("clock gated off", 16'h0000, {15'h0, module_clk_en_out});
        check_access(1'b0);
        ksc_write(16'h0000);
        suspend_cmd <= 1'b0;
        clockoff_cmd <= 1'b0;
        cycles(6);
        check("clock back on", 16'h0001, {15'h0, module_clk_en_out});
        check("normal mode back", {14'h0, KMODE_RUN0}, {14'h0, kernel_mode_out});
        @(posedge clock_in);
        converter_power_sel_in <= PWR_ON;
        cycles(3);
        check("converter on", 16'h0001, {15'h0, converter_active_out});
        conv_run(11, 16);
        @(posedge clock_in);
        converter_power_sel_in <= PWR_SLOW;
        cycles(3);
        conv_run(WAKE_SIM + 11, WAKE_SIM + 20);
        cycles(3);
        check("slow stand-by after", 16'h0000, {15'h0, converter_active_out});
        @(posedge clock_in);
        converter_power_sel_in <= PWR_FAST;
        cycles(3);
        conv_run(WAKE_FAST_CYC + 11, WAKE_FAST_CYC + 20);
        @(posedge clock_in);
        converter_power_sel_in <= PWR_OFF;
        cycles(3);
        check("converter off", 16'h0001, {15'h0, converter_reset_out});
        @(posedge clock_in);
        converter_power_sel_in <= PWR_ON;
        cycles(40);
        pulse_req();
        watch(3);
        ksc_write(16'h00A0);
        pulse_req();
        watch(40);
        check("running conversion finishes", 16'h0001, 16'(cnt_done));
        check("no start in stop", 16'h0000, 16'(cnt_start));
        ksc_write(16'h0080);
        // the frozen request starts in the very cycle the run mode returns
        check("frozen request starts", 16'h0001, {15'h0, conv_start_out});
        cycles(20);
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clock_in);
            analog_clk_divider_in <= 6'($random(seed) & 7);
            arbiter_clk_divider_in <= 2'($random(seed));
            cycles(3);
            watch(240);
            near("converter ticks", 240 / (analog_clk_divider_in + 1), cnt_tick);
            near("arbiter ticks", 240 / (arbiter_clk_divider_in + 1), cnt_arb);
            near("arbiter rounds", 60 / (arbiter_clk_divider_in + 1), cnt_end);
        end
        ksc_write(16'h0002);
        check("off at once", 16'h0000, {15'h0, module_clk_en_out});
        check_access(1'b0);
        @(posedge clock_in);
        rstn_in <= 1'b0;
        cycles(2);
        @(posedge clock_in);
        rstn_in <= 1'b1;
        ksc_m = KSC_RESET;
        arbiter_clk_divider_in <= 2'h0;
        ksc_write(16'h0003);
        ksc_write(16'h00B0);
        check("stop mode 1 applied", {14'h0, KMODE_STOP1}, {14'h0, kernel_mode_out});
        cycles(8);
        watch(40);
        near("arbiter halted", 0, cnt_end * 2);
        give_verdict();
    end
endmodule
